// >>> design/sksf_defines.svh
// Constants of the sense-key-specific byte formatter
// Notes on behaviour
// - Sense key selects layout of bytes 15-17
// - Key 5h: valid, C/D, bit pointer fields, field pointer
// - Illegal-request valid flag set when content meaningful
// - C/D set for CDB, clear for data-out
// - BIT_POINTER_VALID set only when bit pointer significant
// - Bit pointer names MSB of bad field
// - Field pointer names MSB byte, from zero
// - Keys 1h,4h,3h report retry count MSB first
// - Retry layout valid flag tracks count validity
// - Retry count equals retries actually performed; the counter here saturates at FFFFh
// - Key 2h content only during immediate format
// - Progress numerator over 10000h in bytes 16-17
// - Progress valid in bit 7, rest reserved
`ifndef SKSF_DEFINES_SVH
`define SKSF_DEFINES_SVH

`define SKSF_ADDR_CTRL      8'h00
`define SKSF_ADDR_POINTER   8'h04
`define SKSF_ADDR_RETRY     8'h08
`define SKSF_ADDR_BYTES     8'h0C
`define SKSF_ADDR_INT_STAT  8'h10
`define SKSF_ADDR_INT_CLR   8'h14
`define SKSF_ADDR_INT_EN    8'h18
`define SKSF_ADDR_FORMAT    8'h1C

`define SKSF_POS_FIELD_PTR  0
`define SKSF_POS_BIT_PTR    16
`define SKSF_POS_BIT_PTR_VALID 19
`define SKSF_POS_CMD_DATA   20
`define SKSF_POS_PTR_VALID  21
`define SKSF_POS_RTY_VALID  16
`define SKSF_POS_RTY_CLEAR  17

`define SKSF_KEY_RECOVERED  4'h1
`define SKSF_KEY_NOT_READY  4'h2
`define SKSF_KEY_MEDIUM     4'h3
`define SKSF_KEY_HARDWARE   4'h4
`define SKSF_KEY_ILLEGAL    4'h5

`define SKSF_OPC_FORMAT     8'h04
`define SKSF_RETRY_MAX      16'hFFFF

`define SKSF_INT_FMT_START  0
`define SKSF_INT_RTY_SAT    1
`define SKSF_INT_FMT_DONE   2
`define SKSF_INT_WIDTH      3

`define SKSF_RST_WORD       32'h0000_0000
`define SKSF_RST_BYTES      24'h00_0000

`endif

// >>> design/sksf_pkg.sv
// Types shared by the sense-key-specific byte formatter
package sksf_pkg;

  typedef struct packed {
    logic        ptrValid;
    logic        cmdData;
    logic        bitPointerValid;
    logic [2:0]  bitPointer;
    logic [15:0] fieldPointer;
  } sksf_ptr_type;

  typedef struct packed {
    logic [7:0] byte15;
    logic [7:0] byte16;
    logic [7:0] byte17;
  } sksf_bytes_type;

  typedef enum logic [1:0] {
    SKSF_FMT_IDLE = 2'b00,
    SKSF_FMT_RUN  = 2'b01
  } sksf_fmt_type;

endpackage

// >>> design/sksf_layout.sv
// Selects and packs the layout of sense bytes 15 to 17 from the sense key
`timescale 1ns/1ps
`include "sksf_defines.svh"

module sksf_layout (
  input  wire logic                    [3:0]  senseKey,
  input  wire sksf_pkg::sksf_ptr_type         errPtr,
  input  wire logic                    [15:0] retryCount,
  input  wire logic                           retryValid,
  input  wire logic                    [15:0] progress,
  input  wire logic                           progressValid,
  input  wire logic                           formatActive,
  output sksf_pkg::sksf_bytes_type            bytesOut
);

  always_comb begin
    bytesOut = `SKSF_RST_BYTES;
    case (senseKey)
      `SKSF_KEY_ILLEGAL: begin
        // Nothing meaningful means all three bytes stay zero
        if (errPtr.ptrValid) begin
          bytesOut.byte15[7] = 1'b1;
          bytesOut.byte15[6] = errPtr.cmdData;
          bytesOut.byte15[3] = errPtr.bitPointerValid;
          // A meaningless bit pointer is not passed through
          if (errPtr.bitPointerValid) begin
            bytesOut.byte15[2:0] = errPtr.bitPointer;
          end
          bytesOut.byte16 = errPtr.fieldPointer[15:8];
          bytesOut.byte17 = errPtr.fieldPointer[7:0];
        end
      end
      `SKSF_KEY_RECOVERED, `SKSF_KEY_MEDIUM, `SKSF_KEY_HARDWARE: begin
        if (retryValid) begin
          bytesOut.byte15[7] = 1'b1;
          bytesOut.byte16 = retryCount[15:8];
          bytesOut.byte17 = retryCount[7:0];
        end
      end
      `SKSF_KEY_NOT_READY: begin
        if (formatActive && progressValid) begin
          bytesOut.byte15[7] = 1'b1;
          bytesOut.byte16 = progress[15:8];
          bytesOut.byte17 = progress[7:0];
        end
      end
      default: begin
        bytesOut = `SKSF_RST_BYTES;
      end
    endcase
  end

endmodule

// >>> design/sksf_top.sv
// APB-controlled formatter of sense bytes 15 to 17 with retry and format tracking
`timescale 1ns/1ps
`include "sksf_defines.svh"

module sksf_top (
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic                     [7:0]  paddr,
  input  wire logic                     [31:0] pwdata,
  output logic                          [31:0] prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic                            retryStep,
  input  wire logic                            retryClear,
  input  wire logic                            cmdStart,
  input  wire logic                     [7:0]  cmdOpcode,
  input  wire logic                            cmdImmediate,
  input  wire logic                            formatDone,
  input  wire logic                     [15:0] formatProgress,
  input  wire logic                            formatProgressValid,
  output sksf_pkg::sksf_bytes_type             senseBytes,
  output logic                                 irq
);

  logic                     [3:0]               senseKey;
  sksf_pkg::sksf_ptr_type                       errPtr;
  logic                     [15:0]              retryCount;
  logic                                         retryValid;
  sksf_pkg::sksf_fmt_type                       fmtState;
  logic                     [`SKSF_INT_WIDTH-1:0] intStatus;
  logic                     [`SKSF_INT_WIDTH-1:0] intEnable;
  sksf_pkg::sksf_bytes_type                     next_senseBytes;
  logic                     [31:0]              next_prdata;
  logic                                         next_pslverr;
  logic                                         wrAccess;
  logic                                         rdSetup;
  logic                                         formatStart;
  logic                                         formatActive;
  logic                                         retrySat;
  logic                                         retryClrSw;
  logic                     [`SKSF_INT_WIDTH-1:0] intEvents;
  logic                     [`SKSF_INT_WIDTH-1:0] intClear;

  function automatic logic addrMapped(input logic [7:0] addr);
    case (addr)
      `SKSF_ADDR_CTRL, `SKSF_ADDR_POINTER, `SKSF_ADDR_RETRY, `SKSF_ADDR_BYTES,
      `SKSF_ADDR_INT_STAT, `SKSF_ADDR_INT_CLR, `SKSF_ADDR_INT_EN,
      `SKSF_ADDR_FORMAT: begin
        addrMapped = 1'b1;
      end
      default: begin
        addrMapped = 1'b0;
      end
    endcase
  endfunction

  function automatic logic wrHit(input logic       wr,
                                 input logic [7:0] addr,
                                 input logic [7:0] target);
    wrHit = wr && (addr == target);
  endfunction

  // Zero-wait slave: pready rises in the first access cycle
  assign wrAccess = psel && penable && pready && pwrite;
  assign rdSetup  = psel && !penable;

  // Only an immediate format unit opens the progress window
  assign formatStart  = cmdStart && (cmdOpcode == `SKSF_OPC_FORMAT) && cmdImmediate;
  assign formatActive = (fmtState == sksf_pkg::SKSF_FMT_RUN);
  assign retrySat     = retryStep && (retryCount == `SKSF_RETRY_MAX - 16'h0001);
  assign retryClrSw   = wrHit(wrAccess, paddr, `SKSF_ADDR_RETRY)
                        && pwdata[`SKSF_POS_RTY_CLEAR];

  assign intEvents = {formatActive && formatDone, retrySat, formatStart};
  assign intClear  = wrHit(wrAccess, paddr, `SKSF_ADDR_INT_CLR)
                     ? pwdata[`SKSF_INT_WIDTH-1:0] : '0;

  always_comb begin
    next_prdata  = `SKSF_RST_WORD;
    next_pslverr = !addrMapped(paddr);
    case (paddr)
      `SKSF_ADDR_CTRL: begin
        next_prdata[3:0] = senseKey;
      end
      `SKSF_ADDR_POINTER: begin
        next_prdata[`SKSF_POS_PTR_VALID]              = errPtr.ptrValid;
        next_prdata[`SKSF_POS_CMD_DATA]               = errPtr.cmdData;
        next_prdata[`SKSF_POS_BIT_PTR_VALID]          = errPtr.bitPointerValid;
        next_prdata[`SKSF_POS_BIT_PTR +: 3]           = errPtr.bitPointer;
        next_prdata[`SKSF_POS_FIELD_PTR +: 16]        = errPtr.fieldPointer;
      end
      `SKSF_ADDR_RETRY: begin
        next_prdata[15:0]                    = retryCount;
        next_prdata[`SKSF_POS_RTY_VALID]     = retryValid;
      end
      `SKSF_ADDR_BYTES: begin
        next_prdata[23:0] = senseBytes;
      end
      `SKSF_ADDR_INT_STAT: begin
        next_prdata[`SKSF_INT_WIDTH-1:0] = intStatus;
      end
      `SKSF_ADDR_INT_EN: begin
        next_prdata[`SKSF_INT_WIDTH-1:0] = intEnable;
      end
      `SKSF_ADDR_FORMAT: begin
        next_prdata[16]   = formatActive;
        next_prdata[17]   = formatProgressValid;
        next_prdata[15:0] = formatProgress;
      end
      default: begin
        next_prdata = `SKSF_RST_WORD;
      end
    endcase
  end

  // APB answer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `SKSF_RST_WORD;
    end else begin
      pready  <= rdSetup;
      pslverr <= rdSetup && next_pslverr;
      if (rdSetup && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  // Sense key and error pointer written by firmware
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      senseKey <= 4'h0;
      errPtr   <= '0;
    end else begin
      if (wrHit(wrAccess, paddr, `SKSF_ADDR_CTRL)) begin
        senseKey <= pwdata[3:0];
      end
      if (wrHit(wrAccess, paddr, `SKSF_ADDR_POINTER)) begin
        errPtr.ptrValid        <= pwdata[`SKSF_POS_PTR_VALID];
        errPtr.cmdData         <= pwdata[`SKSF_POS_CMD_DATA];
        errPtr.bitPointerValid <= pwdata[`SKSF_POS_BIT_PTR_VALID];
        errPtr.bitPointer      <= pwdata[`SKSF_POS_BIT_PTR +: 3];
        errPtr.fieldPointer    <= pwdata[`SKSF_POS_FIELD_PTR +: 16];
      end
    end
  end

  // Retry counter: a step in the clearing cycle still counts, so no retry is lost
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      retryCount <= 16'h0000;
    end else if (retryClear || retryClrSw) begin
      retryCount <= retryStep ? 16'h0001 : 16'h0000;
    end else if (retryStep && (retryCount != `SKSF_RETRY_MAX)) begin
      retryCount <= retryCount + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      retryValid <= 1'b0;
    end else if (wrHit(wrAccess, paddr, `SKSF_ADDR_RETRY)) begin
      retryValid <= pwdata[`SKSF_POS_RTY_VALID];
    end
  end

  // Format window; a new immediate format restarts it even if one runs
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      fmtState <= sksf_pkg::SKSF_FMT_IDLE;
    end else begin
      case (fmtState)
        sksf_pkg::SKSF_FMT_IDLE: begin
          if (formatStart) begin
            fmtState <= sksf_pkg::SKSF_FMT_RUN;
          end
        end
        sksf_pkg::SKSF_FMT_RUN: begin
          if (formatDone && !formatStart) begin
            fmtState <= sksf_pkg::SKSF_FMT_IDLE;
          end
        end
        default: begin
          fmtState <= sksf_pkg::SKSF_FMT_IDLE;
        end
      endcase
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      intStatus <= '0;
      intEnable <= '0;
      irq       <= 1'b0;
    end else begin
      intStatus <= (intStatus & ~intClear) | intEvents;
      if (wrHit(wrAccess, paddr, `SKSF_ADDR_INT_EN)) begin
        intEnable <= pwdata[`SKSF_INT_WIDTH-1:0];
      end
      irq <= |(intStatus & intEnable);
    end
  end

  sksf_layout u_layout (
    .senseKey      (senseKey),
    .errPtr        (errPtr),
    .retryCount    (retryCount),
    .retryValid    (retryValid),
    .progress      (formatProgress),
    .progressValid (formatProgressValid),
    .formatActive  (formatActive),
    .bytesOut      (next_senseBytes)
  );

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      senseBytes <= `SKSF_RST_BYTES;
    end else begin
      senseBytes <= next_senseBytes;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  a_illegal_layout: assert property (
    (senseKey == `SKSF_KEY_ILLEGAL) && errPtr.ptrValid |=>
      (senseBytes.byte15[7:6] == {1'b1, $past(errPtr.cmdData)}) &&
      ({senseBytes.byte16, senseBytes.byte17} == $past(errPtr.fieldPointer)))
    else $error("illegal-request layout wrong");

  a_illegal_invalid: assert property (
    (senseKey == `SKSF_KEY_ILLEGAL) && !errPtr.ptrValid |=> senseBytes == 24'h00_0000)
    else $error("invalid error pointer not zero");

  a_bit_pointer: assert property (
    (senseKey == `SKSF_KEY_ILLEGAL) && errPtr.ptrValid |=>
      senseBytes.byte15[3:0] == ($past(errPtr.bitPointerValid)
                                 ? {1'b1, $past(errPtr.bitPointer)} : 4'h0))
    else $error("bit pointer field wrong");

  a_reserved_zero: assert property (
    (senseKey == `SKSF_KEY_ILLEGAL) |=> senseBytes.byte15[5:4] == 2'b00)
    else $error("reserved bits set");

  a_retry_layout: assert property (
    ((senseKey == `SKSF_KEY_RECOVERED) || (senseKey == `SKSF_KEY_MEDIUM) ||
     (senseKey == `SKSF_KEY_HARDWARE)) |=>
      (senseBytes.byte15 == {$past(retryValid), 7'h00}) &&
      ({senseBytes.byte16, senseBytes.byte17} ==
       ($past(retryValid) ? $past(retryCount) : 16'h0000)))
    else $error("retry layout wrong");

  a_retry_count: assert property (
    retryStep && !retryClear && !retryClrSw && (retryCount != `SKSF_RETRY_MAX) |=>
      retryCount == $past(retryCount) + 16'h0001)
    else $error("retry not counted");

  a_format_window: assert property (
    formatStart |=> formatActive)
    else $error("immediate format not tracked");

  a_not_ready_idle: assert property (
    (senseKey == `SKSF_KEY_NOT_READY) && !formatActive |=> senseBytes == 24'h00_0000)
    else $error("not-ready content outside format");

  a_progress: assert property (
    (senseKey == `SKSF_KEY_NOT_READY) && formatActive && formatProgressValid |=>
      (senseBytes.byte15 == 8'h80) &&
      ({senseBytes.byte16, senseBytes.byte17} == $past(formatProgress)))
    else $error("progress layout wrong");

  a_other_keys: assert property (
    (senseKey > `SKSF_KEY_ILLEGAL) || (senseKey == 4'h0) |=> senseBytes == 24'h00_0000)
    else $error("undefined key not zero");

  a_irq_level: assert property (
    irq == (|($past(intStatus) & $past(intEnable))))
    else $error("irq does not follow enabled status");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  a_apb_error: assert property (
    psel && !penable && !addrMapped(paddr) |=> pready && pslverr)
    else $error("unmapped access without error");

  a_apb_ok: assert property (
    psel && !penable && addrMapped(paddr) |=> !pslverr)
    else $error("mapped access flagged as error");

  a_apb_read: assert property (
    psel && !penable && !pwrite |=> prdata == $past(next_prdata))
    else $error("read data not presented");

  a_cmd_data: assert property (
    (senseKey == `SKSF_KEY_ILLEGAL) && errPtr.ptrValid && !errPtr.cmdData |=>
      !senseBytes.byte15[6])
    else $error("command/data flag wrong");

  a_retry_invalid: assert property (
    ((senseKey == `SKSF_KEY_RECOVERED) || (senseKey == `SKSF_KEY_MEDIUM) ||
     (senseKey == `SKSF_KEY_HARDWARE)) && !retryValid |=> senseBytes == 24'h00_0000)
    else $error("invalid retry count shown");

  a_progress_invalid: assert property (
    (senseKey == `SKSF_KEY_NOT_READY) && !formatProgressValid |=> senseBytes == 24'h00_0000)
    else $error("invalid progress shown");

  a_retry_clear: assert property (
    retryClear || retryClrSw |=> retryCount == {15'h0000, $past(retryStep)})
    else $error("retry clear wrong");

  a_retry_hold: assert property (
    !retryStep && !retryClear && !retryClrSw |=> $stable(retryCount))
    else $error("retry count moved without a step");

  a_retry_saturate: assert property (
    retryStep && !retryClear && !retryClrSw && (retryCount == `SKSF_RETRY_MAX) |=>
      retryCount == `SKSF_RETRY_MAX)
    else $error("retry count wrapped");

  a_format_close: assert property (
    formatActive && formatDone && !formatStart |=> !formatActive)
    else $error("format window not closed");

  a_format_refused: assert property (
    !formatActive && !formatStart |=> !formatActive)
    else $error("format window opened without start");

  a_status_set_wins: assert property (
    (intEvents != '0) |=> (intStatus & $past(intEvents)) == $past(intEvents))
    else $error("event lost in status");

  a_status_clear: assert property (
    1'b1 |=> (intStatus & $past(intClear) & ~$past(intEvents)) == '0)
    else $error("status bit not cleared");

endmodule

// >>> bench/sksf_initiator_model.sv
// Initiator-side model that fetches sense bytes 15 to 17
`timescale 1ns/1ps

module sksf_initiator_model (
  input  wire logic                     clk_sys,
  input  wire logic                     fetch,
  input  wire sksf_pkg::sksf_bytes_type senseBytes,
  output logic                   [7:0]  flagByte,
  output logic                   [15:0] value
);
  // Joins bytes 16 and 17 most significant first, as the initiator reads them
  always_ff @(posedge clk_sys) begin
    if (fetch) begin
      flagByte <= senseBytes.byte15;
      value    <= {senseBytes.byte16, senseBytes.byte17};
    end
  end
endmodule

// >>> bench/test_sense_key_specific_formatter.sv
// Self-checking bench of the sense-key-specific byte formatter
`timescale 1ns/1ps
`include "sksf_defines.svh"

module test_sense_key_specific_formatter;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  logic                     clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]               paddr, cmdOpcode, flagByte;
  logic [31:0]              pwdata, prdata, rdData;
  logic                     retryStep, retryClear, cmdStart, cmdImmediate, formatDone;
  logic [15:0]              formatProgress, value;
  logic                     formatProgressValid, irq, fetch, rdErr;
  sksf_pkg::sksf_bytes_type senseBytes;
  int                       num_errors = 0;
  int                       n_tests = 0;

  sksf_top dut (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .retryStep(retryStep),
    .retryClear(retryClear), .cmdStart(cmdStart), .cmdOpcode(cmdOpcode),
    .cmdImmediate(cmdImmediate), .formatDone(formatDone),
    .formatProgress(formatProgress), .formatProgressValid(formatProgressValid),
    .senseBytes(senseBytes), .irq(irq)
  );

  sksf_initiator_model host (
    .clk_sys(clk_sys), .fetch(fetch), .senseBytes(senseBytes),
    .flagByte(flagByte), .value(value)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on pready with a bound instead of assuming the zero-wait answer
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      num_errors++;
      $display("Error at %0t: no pready", $time);
      report_and_stop();
    end
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sense(input logic [23:0] exp);
    repeat (2) @(posedge clk_sys);
    fetch <= 1'b1;
    @(posedge clk_sys);
    fetch <= 1'b0;
    @(negedge clk_sys);
    check({8'h00, flagByte, value}, {8'h00, exp});
  endtask

  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    check({31'h0000_0000, irq}, {31'h0000_0000, exp});
  endtask

  task automatic step(input int n);
    @(posedge clk_sys);
    retryStep <= 1'b1;
    repeat (n) @(posedge clk_sys);
    retryStep <= 1'b0;
  endtask

  task automatic start(input logic [7:0] opc, input logic imm);
    @(posedge clk_sys);
    cmdStart     <= 1'b1;
    cmdOpcode    <= opc;
    cmdImmediate <= imm;
    @(posedge clk_sys);
    cmdStart <= 1'b0;
  endtask

  task automatic t_reset();
    @(negedge clk_sys);
    check({8'h00, senseBytes}, ZERO);
    check({31'h0000_0000, irq}, ZERO);
    apb(1'b1, `SKSF_ADDR_CTRL, 32'hFFFF_FFF5);
    apb(1'b0, `SKSF_ADDR_CTRL, ZERO);
    check(rdData, 32'h0000_0005);
    apb(1'b0, 8'h40, ZERO);
    check({rdData[31:1], rdErr}, 32'h0000_0001);
  endtask

  task automatic t_illegal();
    apb(1'b1, `SKSF_ADDR_POINTER, 32'h003D_1234);
    sense(24'hCD_1234);
    apb(1'b0, `SKSF_ADDR_BYTES, ZERO);
    check(rdData, 32'h00CD_1234);
    apb(1'b1, `SKSF_ADDR_POINTER, 32'h0027_0007);
    sense(24'h80_0007);
    apb(1'b1, `SKSF_ADDR_POINTER, 32'h0017_FFFF);
    sense(24'h00_0000);
  endtask

  task automatic t_retry();
    logic [3:0] keys [3] = '{`SKSF_KEY_RECOVERED, `SKSF_KEY_MEDIUM, `SKSF_KEY_HARDWARE};
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `SKSF_ADDR_CTRL, {28'h000_0000, keys[k]});
      apb(1'b1, `SKSF_ADDR_RETRY, 32'h0003_0000);
      sense(24'h80_0000);
      step(k + 2);
      sense({8'h80, 16'(k + 2)});
      apb(1'b1, `SKSF_ADDR_RETRY, ZERO);
      sense(24'h00_0000);
      // A step in the clearing cycle must survive as a count of one
      @(posedge clk_sys);
      retryClear <= 1'b1;
      retryStep  <= 1'b1;
      @(posedge clk_sys);
      retryClear <= 1'b0;
      retryStep  <= 1'b0;
      apb(1'b0, `SKSF_ADDR_RETRY, ZERO);
      check(rdData, 32'h0000_0001);
    end
  endtask

  // Count saturation also drives the interrupt path: raise, mask, clear
  task automatic t_irq();
    apb(1'b1, `SKSF_ADDR_RETRY, 32'h0001_0000);
    apb(1'b1, `SKSF_ADDR_INT_EN, 32'h0000_0002);
    step(65540);
    sense(24'h80_FFFF);
    chk_irq(1'b1);
    apb(1'b0, `SKSF_ADDR_INT_STAT, ZERO);
    check(rdData, 32'h0000_0002);
    apb(1'b1, `SKSF_ADDR_INT_EN, ZERO);
    chk_irq(1'b0);
    apb(1'b1, `SKSF_ADDR_INT_EN, 32'h0000_0007);
    chk_irq(1'b1);
    apb(1'b1, `SKSF_ADDR_RETRY, 32'h0002_0000);
    apb(1'b1, `SKSF_ADDR_INT_CLR, 32'h0000_0002);
    chk_irq(1'b0);
  endtask

  task automatic t_not_ready();
    apb(1'b1, `SKSF_ADDR_CTRL, {28'h000_0000, `SKSF_KEY_NOT_READY});
    formatProgress      <= 16'h4000;
    formatProgressValid <= 1'b1;
    sense(24'h00_0000);
    start(`SKSF_OPC_FORMAT, 1'b0);
    sense(24'h00_0000);
    start(8'h05, 1'b1);
    sense(24'h00_0000);
    start(`SKSF_OPC_FORMAT, 1'b1);
    sense(24'h80_4000);
    apb(1'b0, `SKSF_ADDR_FORMAT, ZERO);
    check(rdData, 32'h0003_4000);
    formatProgressValid <= 1'b0;
    sense(24'h00_0000);
    @(posedge clk_sys);
    formatProgressValid <= 1'b1;
    formatDone          <= 1'b1;
    @(posedge clk_sys);
    formatDone <= 1'b0;
    sense(24'h00_0000);
    apb(1'b0, `SKSF_ADDR_INT_STAT, ZERO);
    check(rdData, 32'h0000_0005);
    chk_irq(1'b1);
  endtask

  task automatic t_other_keys();
    apb(1'b1, `SKSF_ADDR_POINTER, 32'h003D_1234);
    apb(1'b1, `SKSF_ADDR_RETRY, 32'h0001_0000);
    for (int k = 0; k < 16; k++) begin
      if (k == 0 || k > 5) begin
        apb(1'b1, `SKSF_ADDR_CTRL, 32'(k));
        sense(24'h00_0000);
      end
    end
  endtask

  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = ZERO;
    retryStep = 1'b0;
    retryClear = 1'b0;
    cmdStart = 1'b0;
    cmdOpcode = 8'h00;
    cmdImmediate = 1'b0;
    formatDone = 1'b0;
    formatProgress = 16'h0000;
    formatProgressValid = 1'b0;
    fetch = 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_illegal();
    t_retry();
    t_irq();
    t_not_ready();
    t_other_keys();
    report_and_stop();
  end
endmodule
